// [rtl/dcc_cal_engine.sv]
// Purpose: sequences the measurements of one calibration request
// Assumes: front end answers each meas_req_o with one meas_ack_i pulse
// Notes: req stays high until ack, then drops one cycle before the next
`timescale 1ns/100ps
`include "dcc_consts.svh"
module dcc_cal_engine #(
  parameter int DW = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire dcc_pkg::dcc_code_t code_i,
  input wire logic meas_ack_i,
  input wire logic [DW-1:0] meas_a_i,
  input wire logic [DW-1:0] meas_b_i,
  output logic busy_o,
  output logic meas_req_o,
  output dcc_pkg::dcc_chan_e meas_chan_o,
  output logic res_valid_o,
  output dcc_pkg::dcc_chan_e res_chan_o,
  output logic [DW-1:0] res_a_o,
  output logic [DW-1:0] res_b_o,
  output logic done_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_MEAS, ST_GAP} dcc_eng_e;
  dcc_eng_e st_q;
  dcc_pkg::dcc_chan_e last_q;
  dcc_pkg::dcc_chan_e first_w;
  dcc_pkg::dcc_chan_e last_w;
  wire logic at_last_w = (meas_chan_o == last_q);

  // code 0 never reaches here; the top filters it out
  assign first_w = (code_i == `DCC_CODE_TRQ) ? dcc_pkg::DCC_CH_TRQ :
                   (code_i == `DCC_CODE_CV) ? dcc_pkg::DCC_CH_CV :
                   (code_i == `DCC_CODE_CW) ? dcc_pkg::DCC_CH_CW :
                   (code_i == `DCC_CODE_THERM) ? dcc_pkg::DCC_CH_THERM :
                   dcc_pkg::DCC_CH_SPD;
  assign last_w = (code_i == `DCC_CODE_ALL) ? dcc_pkg::DCC_CH_CW : first_w;

  always_ff @(posedge clk_i) begin
    res_valid_o <= 1'b0;
    done_o <= 1'b0;
    if (rst_i) begin
      st_q <= ST_IDLE;
      last_q <= dcc_pkg::DCC_CH_SPD;
      meas_chan_o <= dcc_pkg::DCC_CH_SPD;
      res_chan_o <= dcc_pkg::DCC_CH_SPD;
      res_a_o <= '0;
      res_b_o <= '0;
      meas_req_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (start_i) begin
            st_q <= ST_MEAS;
            meas_chan_o <= first_w;
            last_q <= last_w;
            meas_req_o <= 1'b1;
            busy_o <= 1'b1;
          end
        end
        ST_MEAS: begin
          if (meas_ack_i) begin
            meas_req_o <= 1'b0;
            res_valid_o <= 1'b1;
            res_chan_o <= meas_chan_o;
            res_a_o <= meas_a_i;
            res_b_o <= meas_b_i;
            if (at_last_w) begin
              st_q <= ST_IDLE;
              busy_o <= 1'b0;
              done_o <= 1'b1;
            end else begin
              st_q <= ST_GAP;
            end
          end
        end
        ST_GAP: begin
          // walk speed, torque, V, W in order for the combined run
          st_q <= ST_MEAS;
          meas_chan_o <= dcc_pkg::dcc_chan_e'(meas_chan_o + 3'h1);
          meas_req_o <= 1'b1;
        end
      endcase
    end
  end
endmodule : dcc_cal_engine

// [rtl/dcc_consts.svh]
// Purpose: constants of the drift calibration control block
// Assumes: 32-bit classic Wishbone, register byte address = index * 4
// Notes: definitions only
//
// Contract
// - code 1 calibrates speed input, code 2 calibrates torque input
// - code 3 calibrates first current phase, code 4 the second phase
// - code 5 runs speed, torque and both current calibrations together
// - code 6 calibrates power stage thermistor; code 0 starts nothing
// - calibration codes act only while parameter mode setting equals 20
// - offsets written by hand only while parameter mode setting is 22
// - mode 20 then code; results stored in offsets, range 0 to 32767
// - parameter mode setting 10 refuses any change of offset parameters
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH

// register indices; byte address is index * 4
`define DCC_IDX_CMD 12'h40A
`define DCC_IDX_SPD_A 12'h40B
`define DCC_IDX_SPD_B 12'h40C
`define DCC_IDX_TRQ_A 12'h40D
`define DCC_IDX_TRQ_B 12'h40E
`define DCC_IDX_CV_A 12'h40F
`define DCC_IDX_CV_B 12'h410
`define DCC_IDX_CW_A 12'h411
`define DCC_IDX_CW_B 12'h412
`define DCC_IDX_THERM 12'h413
`define DCC_IDX_MODE 12'h208
`define DCC_IDX_STAT 12'h420

`define DCC_RST_CMD 16'h0000
`define DCC_RST_MODE 16'h0000
`define DCC_RST_OFS 16'h0000

`define DCC_MODE_LOCK 16'h000A
`define DCC_MODE_AUTO 16'h0014
`define DCC_MODE_MANUAL 16'h0016

`define DCC_CODE_NONE 3'h0
`define DCC_CODE_SPD 3'h1
`define DCC_CODE_TRQ 3'h2
`define DCC_CODE_CV 3'h3
`define DCC_CODE_CW 3'h4
`define DCC_CODE_ALL 3'h5
`define DCC_CODE_THERM 3'h6

// status fields
`define DCC_ST_BUSY 0
`define DCC_ST_REFUSED 1
`define DCC_ST_CODE_LO 4
`define DCC_ST_CODE_HI 6
`define DCC_ST_MODE_OK 8

`define DCC_OFS_MAX 16'h7FFF
`endif

// [rtl/dcc_pkg.sv]
// Purpose: shared types of the drift calibration control block
// Assumes: nothing beyond the constants header
// Notes: channel numbering matches meas_chan_o
package dcc_pkg;
  typedef enum logic [2:0] {
    DCC_CH_SPD,
    DCC_CH_TRQ,
    DCC_CH_CV,
    DCC_CH_CW,
    DCC_CH_THERM
  } dcc_chan_e;
  typedef logic [2:0] dcc_code_t;
endpackage : dcc_pkg

// [rtl/dcc_top.sv]
// Purpose: calibration command and offset parameter registers
// Assumes: classic Wishbone slave, 32-bit data, one wait state
// Notes: analog measurement lives outside, behind the meas_* ports
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "dcc_consts.svh"
module dcc_top #(
  parameter int AW = 16,
  parameter int DW = 16,
  parameter logic [15:0] OFS_INIT = `DCC_RST_OFS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic meas_ack_i,
  input wire logic [DW-1:0] meas_a_i,
  input wire logic [DW-1:0] meas_b_i,
  output logic meas_req_o,
  output dcc_pkg::dcc_chan_e meas_chan_o,
  output logic cal_busy_o,
  output logic cal_done_o
);
  // merge byte lanes 0 and 1 into a 16-bit register
  function automatic logic [15:0] merge16(
    input logic [15:0] old_v,
    input logic [31:0] dat,
    input logic [3:0] sel
  );
    logic [15:0] r;
    r = old_v;
    if (sel[0]) begin
      r[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      r[15:8] = dat[15:8];
    end
    return r;
  endfunction : merge16

  // offsets never leave 0..32767
  function automatic logic [15:0] clamp_ofs(
    input logic [15:0] v
  );
    return v & `DCC_OFS_MAX;
  endfunction : clamp_ofs

  function automatic logic [31:0] zx(
    input logic [15:0] v
  );
    return {16'h0000, v};
  endfunction : zx

  // bus handshake
  wire logic req_w = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic wr_w = req_w & wb_we_i;
  wire logic [AW-3:0] idx_w = wb_adr_i[AW-1:2];
  wire logic [11:0] ix_w = 12'(idx_w);

  wire logic hit_cmd_w = (ix_w == `DCC_IDX_CMD);
  wire logic hit_spa_w = (ix_w == `DCC_IDX_SPD_A);
  wire logic hit_spb_w = (ix_w == `DCC_IDX_SPD_B);
  wire logic hit_tqa_w = (ix_w == `DCC_IDX_TRQ_A);
  wire logic hit_tqb_w = (ix_w == `DCC_IDX_TRQ_B);
  wire logic hit_cva_w = (ix_w == `DCC_IDX_CV_A);
  wire logic hit_cvb_w = (ix_w == `DCC_IDX_CV_B);
  wire logic hit_cwa_w = (ix_w == `DCC_IDX_CW_A);
  wire logic hit_cwb_w = (ix_w == `DCC_IDX_CW_B);
  wire logic hit_th_w = (ix_w == `DCC_IDX_THERM);
  wire logic hit_mode_w = (ix_w == `DCC_IDX_MODE);
  wire logic hit_stat_w = (ix_w == `DCC_IDX_STAT);
  wire logic hit_ofs_w = hit_spa_w | hit_spb_w | hit_tqa_w | hit_tqb_w
                       | hit_cva_w | hit_cvb_w | hit_cwa_w | hit_cwb_w
                       | hit_th_w;
  wire logic hit_any_w = hit_cmd_w | hit_ofs_w | hit_mode_w | hit_stat_w;

  // registers
  logic [15:0] mode_q;
  logic [15:0] mode_d;
  dcc_pkg::dcc_code_t cmd_q;
  dcc_pkg::dcc_code_t cmd_d;
  logic [15:0] spa_q;
  logic [15:0] spb_q;
  logic [15:0] tqa_q;
  logic [15:0] tqb_q;
  logic [15:0] cva_q;
  logic [15:0] cvb_q;
  logic [15:0] cwa_q;
  logic [15:0] cwb_q;
  logic [15:0] th_q;
  logic refused_q;
  logic refused_d;
  logic [31:0] rd_d;

  // mode decode
  wire logic mode_auto_w = (mode_q == `DCC_MODE_AUTO);
  wire logic mode_man_w = (mode_q == `DCC_MODE_MANUAL);
  wire logic mode_lock_w = (mode_q == `DCC_MODE_LOCK);

  // engine hookup
  logic eng_busy;
  logic eng_valid;
  logic eng_done;
  dcc_pkg::dcc_chan_e eng_chan;
  logic [DW-1:0] eng_a;
  logic [DW-1:0] eng_b;

  // command write: code must be 0..6 and the engine idle
  wire dcc_pkg::dcc_code_t wcode_w = wb_dat_i[2:0];
  wire logic code_range_w = (wb_dat_i[15:3] == 13'h0000)
                          & (wcode_w <= `DCC_CODE_THERM);
  wire logic cmd_wr_w = wr_w & hit_cmd_w & wb_sel_i[0];
  wire logic cmd_ok_w = cmd_wr_w & mode_auto_w & code_range_w & ~eng_busy;
  wire logic start_w = cmd_ok_w & (wcode_w != `DCC_CODE_NONE);
  wire logic cmd_bad_w = cmd_wr_w & ~cmd_ok_w;

  // manual offset write: only mode 22, never under the lock mode
  wire logic ofs_wr_w = wr_w & hit_ofs_w;
  wire logic ofs_ok_w = mode_man_w & ~mode_lock_w;
  wire logic ofs_bad_w = ofs_wr_w & ~ofs_ok_w;

  // results are dropped if the block was locked mid-run
  wire logic res_ok_w = eng_valid & ~mode_lock_w;
  wire logic res_sp_w = res_ok_w & (eng_chan == dcc_pkg::DCC_CH_SPD);
  wire logic res_tq_w = res_ok_w & (eng_chan == dcc_pkg::DCC_CH_TRQ);
  wire logic res_cv_w = res_ok_w & (eng_chan == dcc_pkg::DCC_CH_CV);
  wire logic res_cw_w = res_ok_w & (eng_chan == dcc_pkg::DCC_CH_CW);
  wire logic res_th_w = res_ok_w & (eng_chan == dcc_pkg::DCC_CH_THERM);
  wire logic [15:0] ra_w = clamp_ofs(16'(eng_a));
  wire logic [15:0] rb_w = clamp_ofs(16'(eng_b));

  // per register next value: result wins over a same-cycle manual write
  function automatic logic [15:0] ofs_next(
    input logic [15:0] cur,
    input logic res_hit,
    input logic [15:0] res_v,
    input logic bus_hit,
    input logic [31:0] dat,
    input logic [3:0] sel
  );
    logic [15:0] r;
    r = cur;
    if (res_hit) begin
      r = res_v;
    end else if (bus_hit) begin
      r = clamp_ofs(merge16(cur, dat, sel));
    end
    return r;
  endfunction : ofs_next

  wire logic mw_w = wr_w & ofs_ok_w;
  wire logic [15:0] spa_d = ofs_next(spa_q, res_sp_w, ra_w, mw_w & hit_spa_w,
                                     wb_dat_i, wb_sel_i);
  wire logic [15:0] spb_d = ofs_next(spb_q, res_sp_w, rb_w, mw_w & hit_spb_w,
                                     wb_dat_i, wb_sel_i);
  wire logic [15:0] tqa_d = ofs_next(tqa_q, res_tq_w, ra_w, mw_w & hit_tqa_w,
                                     wb_dat_i, wb_sel_i);
  wire logic [15:0] tqb_d = ofs_next(tqb_q, res_tq_w, rb_w, mw_w & hit_tqb_w,
                                     wb_dat_i, wb_sel_i);
  wire logic [15:0] cva_d = ofs_next(cva_q, res_cv_w, ra_w, mw_w & hit_cva_w,
                                     wb_dat_i, wb_sel_i);
  wire logic [15:0] cvb_d = ofs_next(cvb_q, res_cv_w, rb_w, mw_w & hit_cvb_w,
                                     wb_dat_i, wb_sel_i);
  wire logic [15:0] cwa_d = ofs_next(cwa_q, res_cw_w, ra_w, mw_w & hit_cwa_w,
                                     wb_dat_i, wb_sel_i);
  wire logic [15:0] cwb_d = ofs_next(cwb_q, res_cw_w, rb_w, mw_w & hit_cwb_w,
                                     wb_dat_i, wb_sel_i);
  wire logic [15:0] th_d = ofs_next(th_q, res_th_w, ra_w, mw_w & hit_th_w,
                                    wb_dat_i, wb_sel_i);

  // mode register takes any value
  assign mode_d = (wr_w & hit_mode_w) ? merge16(mode_q, wb_dat_i, wb_sel_i) : mode_q;

  // done clears the command even if a refused write lands alongside;
  // a code taken in the very cycle the last run ends wins over that clear
  assign cmd_d = cmd_ok_w ? wcode_w :
                 eng_done ? `DCC_CODE_NONE : cmd_q;
  // a new refusal beats a clear in the same cycle
  wire logic stat_clr_w = wr_w & hit_stat_w & wb_sel_i[0] & wb_dat_i[`DCC_ST_REFUSED];
  assign refused_d = (cmd_bad_w | ofs_bad_w) ? 1'b1 :
                     stat_clr_w ? 1'b0 : refused_q;

  // status word
  wire logic [15:0] stat_w = {
    7'h00,
    mode_auto_w,
    1'b0,
    cmd_q,
    2'b00,
    refused_q,
    eng_busy
  };

  // read selection; unmapped reads give zero
  assign rd_d = hit_cmd_w ? zx({13'h0000, cmd_q}) :
                hit_spa_w ? zx(spa_q) :
                hit_spb_w ? zx(spb_q) :
                hit_tqa_w ? zx(tqa_q) :
                hit_tqb_w ? zx(tqb_q) :
                hit_cva_w ? zx(cva_q) :
                hit_cvb_w ? zx(cvb_q) :
                hit_cwa_w ? zx(cwa_q) :
                hit_cwb_w ? zx(cwb_q) :
                hit_th_w ? zx(th_q) :
                hit_mode_w ? zx(mode_q) :
                hit_stat_w ? zx(stat_w) :
                32'h00000000;

  // bus answer: ack one cycle after the request, every address acked
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req_w;
    end
  end

  // data only in the ack cycle of a mapped read, zero otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_dat_o <= (req_w & ~wb_we_i & hit_any_w) ? rd_d : 32'h00000000;
    end
  end

  // control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= `DCC_RST_MODE;
    end else begin
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_q <= `DCC_CODE_NONE;
    end else begin
      cmd_q <= cmd_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      refused_q <= 1'b0;
    end else begin
      refused_q <= refused_d;
    end
  end

  // offset parameters; reset value stands in for the factory setting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      spa_q <= OFS_INIT;
    end else begin
      spa_q <= spa_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      spb_q <= OFS_INIT;
    end else begin
      spb_q <= spb_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tqa_q <= OFS_INIT;
    end else begin
      tqa_q <= tqa_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tqb_q <= OFS_INIT;
    end else begin
      tqb_q <= tqb_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cva_q <= OFS_INIT;
    end else begin
      cva_q <= cva_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cvb_q <= OFS_INIT;
    end else begin
      cvb_q <= cvb_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cwa_q <= OFS_INIT;
    end else begin
      cwa_q <= cwa_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cwb_q <= OFS_INIT;
    end else begin
      cwb_q <= cwb_d;
    end
  end

  // thermistor keeps only the a value; no b half exists for it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      th_q <= OFS_INIT;
    end else begin
      th_q <= th_d;
    end
  end

  // servo-off, wiring and standstill are the operator's duty; nothing checks them
  dcc_cal_engine #(
    .DW(DW)
  ) u_eng (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(start_w),
    .code_i(wcode_w),
    .meas_ack_i(meas_ack_i),
    .meas_a_i(meas_a_i),
    .meas_b_i(meas_b_i),
    .busy_o(eng_busy),
    .meas_req_o(meas_req_o),
    .meas_chan_o(meas_chan_o),
    .res_valid_o(eng_valid),
    .res_chan_o(eng_chan),
    .res_a_o(eng_a),
    .res_b_o(eng_b),
    .done_o(eng_done)
  );

  assign cal_busy_o = eng_busy;
  assign cal_done_o = eng_done;
endmodule : dcc_top

// [tb/dcc_top_monitor.sv]
// Purpose: port level checks of the calibration control block
// Assumes: bound into dcc_top, one clock domain
// Notes: register contents are judged by the bench
`timescale 1ns/100ps
module dcc_top_monitor #(
  parameter int AW = 16,
  parameter int DW = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [AW-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic meas_ack_i,
  input wire logic meas_req_o,
  input wire dcc_pkg::dcc_chan_e meas_chan_o,
  input wire logic cal_busy_o,
  input wire logic cal_done_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  dat_quiet_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack cycle");
  dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read half not zero");
  start_by_write_a: assert property ($rose(cal_busy_o) |-> wb_ack_o && wb_we_i && wb_adr_i[15:2] == 14'h040A)
    else $error("calibration started without command write");
  req_in_busy_a: assert property (meas_req_o |-> cal_busy_o)
    else $error("measurement request while idle");
  req_hold_a: assert property (meas_req_o && !meas_ack_i |=> meas_req_o && $stable(meas_chan_o))
    else $error("measurement request not held");
  req_drop_a: assert property (meas_req_o && meas_ack_i |=> !meas_req_o ##1 (meas_req_o == cal_busy_o))
    else $error("measurement request not released");
  busy_end_a: assert property ($fell(cal_busy_o) |-> cal_done_o)
    else $error("busy ended without done");
  done_single_a: assert property (cal_done_o |=> !cal_done_o)
    else $error("done longer than one cycle");
endmodule : dcc_top_monitor

bind dcc_top dcc_top_monitor #(.AW(AW), .DW(DW)) u_dcc_top_monitor (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .meas_ack_i(meas_ack_i),
  .meas_req_o(meas_req_o), .meas_chan_o(meas_chan_o), .cal_busy_o(cal_busy_o), .cal_done_o(cal_done_o)
);

// [tb/dcc_top_test.sv]
// Purpose: register level tests of the calibration control block
// Assumes: bench plays bus master and measurement front end
// Notes: offset shadow holds expected register contents
`timescale 1ns/100ps
module dcc_top_test;
  logic clk_i, rst_i, cyc, stb, we, ack_i;
  logic [15:0] adr, ma, mb;
  logic [3:0] sel;
  logic [31:0] wdat, q;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, meas_req_o, cal_busy_o, cal_done_o;
  dcc_pkg::dcc_chan_e meas_chan_o;
  logic [15:0] sh [0:8];
  int fail_count, cmp_count, lo, hi;
  dcc_top u_dcc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .meas_ack_i(ack_i), .meas_a_i(ma), .meas_b_i(mb), .meas_req_o(meas_req_o),
    .meas_chan_o(meas_chan_o), .cal_busy_o(cal_busy_o), .cal_done_o(cal_done_o));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [11:0] idx, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {2'h0, idx, 2'h0};
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0000_0001, 32'h0000_0000);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    wdat <= ~d;
  endtask : wb
  task automatic wr(input logic [11:0] idx, input logic [15:0] d);
    wb(1'b1, idx, {16'h0000, d}, 4'hF);
  endtask : wr
  task automatic rd(input logic [11:0] idx, input logic [15:0] e);
    wb(1'b0, idx, 32'h0000_0000, 4'hF);
    chk({16'h0000, e}, q);
  endtask : rd
  task automatic check_ofs();
    for (int i = 0; i < 9; i++) rd(12'h40B + i[11:0], sh[i]);
  endtask : check_ofs
  // front end answer; b is ignored for the thermistor channel
  task automatic serve(input int ch, input logic [15:0] a, input logic [15:0] b, input logic locked);
    int n;
    n = 0;
    // the previous ack edge must pass before the request is looked at again
    @(posedge clk_i);
    while (meas_req_o !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'h1, {31'h0, meas_req_o});
    chk(ch, {29'h0, meas_chan_o});
    repeat (3) @(posedge clk_i);
    ack_i <= 1'b1;
    ma <= a;
    mb <= b;
    @(posedge clk_i);
    ack_i <= 1'b0;
    ma <= ~a;
    mb <= ~b;
    if (!locked) begin
      sh[2*ch] = a & 16'h7FFF;
      if (ch < 4) sh[2*ch+1] = b & 16'h7FFF;
    end
  endtask : serve
  task automatic wait_idle();
    int n;
    n = 0;
    while (cal_busy_o !== 1'b0 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'h0, {31'h0, cal_busy_o});
    chk(32'h1, {31'h0, cal_done_o});
  endtask : wait_idle
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    finish_test();
  end
  initial begin
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; ack_i = 1'b0;
    adr = 16'h0000; sel = 4'h0; wdat = 32'h0; ma = 16'h0; mb = 16'h0;
    fail_count = 0; cmp_count = 0;
    for (int i = 0; i < 9; i++) sh[i] = 16'h0000;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(12'h40A, 16'h0000);
    rd(12'h208, 16'h0000);
    check_ofs();
    $display("test reset done");
    wr(12'h40A, 16'h0001);
    rd(12'h40A, 16'h0000);
    rd(12'h420, 16'h0002);
    wr(12'h420, 16'h0002);
    rd(12'h420, 16'h0000);
    wr(12'h208, 16'h0014);
    wr(12'h40B, 16'h1111);
    wr(12'h208, 16'h000A);
    wr(12'h40B, 16'h2222);
    check_ofs();
    wr(12'h208, 16'h0016);
    wr(12'h40B, 16'hFFFF);
    sh[0] = 16'h7FFF;
    wb(1'b1, 12'h40C, 32'h0000_1234, 4'h1);
    sh[1] = 16'h0034;
    check_ofs();
    $display("test manual done");
    wr(12'h208, 16'h0014);
    rd(12'h420, 16'h0102);
    wr(12'h40A, 16'h0000);
    repeat (3) @(posedge clk_i);
    chk(32'h0, {31'h0, cal_busy_o});
    for (int c = 1; c <= 6; c++) begin
      lo = (c == 6) ? 4 : ((c == 5) ? 0 : c - 1);
      hi = (c == 5) ? 3 : lo;
      // bench stands for a drive held servo-off, unwired and at standstill
      wr(12'h40A, c[15:0]);
      rd(12'h40A, c[15:0]);
      for (int ch = lo; ch <= hi; ch++) serve(ch, 16'h8100 + 16'(c * 16 + ch), 16'h4200 + 16'(ch), 1'b0);
      wait_idle();
      rd(12'h40A, 16'h0000);
      check_ofs();
    end
    $display("test auto done");
    wr(12'h40A, 16'h0001);
    wr(12'h40A, 16'h0002);
    rd(12'h40A, 16'h0001);
    wr(12'h208, 16'h000A);
    serve(0, 16'h0ABC, 16'h0DEF, 1'b1);
    wait_idle();
    check_ofs();
    $display("test lock done");
    finish_test();
  end
endmodule : dcc_top_test
